// ### logic/sacfg_pkg.sv
// package of constants and types for the first slot afe configuration registers
// Operation
// - reference voltage field bits 5:4, resets 3
// - per-channel enable: ch1 local, ch2-4 from 0x55
// - enable clear: one gain for all channels
// - gain field bits 1:0 resets to zero
// - bit 7 turns integrator into buffer
// - path word at 0x43 resets 0xADA5
package sacfg_pkg;
    // register indices (printed offsets are not all multiples of four)
    localparam logic [7:0] SACFG_AMP_CTRL_IDX = 8'h42;
    localparam logic [7:0] SACFG_PATH_SEL_IDX = 8'h43;
    localparam logic [7:0] SACFG_CH_GAIN_IDX = 8'h55;
    // field positions in the amp control word
    localparam int SACFG_GAIN_LSB = 0;
    localparam int SACFG_VREF_LSB = 4;
    localparam int SACFG_IND_EN_BIT = 6;
    localparam int SACFG_AS_BUF_BIT = 7;
    // reset values
    localparam logic [15:0] SACFG_AMP_CTRL_RST = 16'h0030;
    localparam logic [15:0] SACFG_PATH_SEL_RST = 16'hADA5;
    localparam logic [15:0] SACFG_CH_GAIN_RST = 16'h0000;
    // defined path codes
    localparam logic [15:0] SACFG_PATH_FULL = 16'hADA5;
    localparam logic [15:0] SACFG_PATH_BUF = 16'hAE65;
    localparam logic [15:0] SACFG_PATH_NOBUF = 16'hB065;
    // axi responses
    localparam logic [1:0] SACFG_RESP_OKAY = 2'h0;
    localparam logic [1:0] SACFG_RESP_SLVERR = 2'h2;

    // decoded analog settings handed to the front end
    typedef struct packed {
        logic [1:0] ref_voltage;
        logic [1:0] gain_ch1;
        logic [1:0] gain_ch2;
        logic [1:0] gain_ch3;
        logic [1:0] gain_ch4;
        logic integrator_as_buffer;
        logic per_channel_gain_enable;
        logic full_analog_chain_mode;
        logic amp_to_adc_mode;
        logic path_reserved;
    } sacfg_afe_s;
endpackage

// ### logic/sacfg_decode.sv
// decode of stored register words into analog front end settings
module sacfg_decode (
    input wire logic [15:0] amp_ctrl,
    input wire logic [15:0] path_sel,
    input wire logic [15:0] ch_gain,
    output sacfg_pkg::sacfg_afe_s afe
);
    import sacfg_pkg::*;
    // local aliases for the fields
    wire logic [1:0] first_slot_amp_gain = amp_ctrl[SACFG_GAIN_LSB +: 2];
    wire logic first_slot_per_channel_gain_enable = amp_ctrl[SACFG_IND_EN_BIT];
    wire logic path_full = (path_sel == SACFG_PATH_FULL);
    wire logic path_buf = (path_sel == SACFG_PATH_BUF);
    wire logic path_nobuf = (path_sel == SACFG_PATH_NOBUF);

    assign afe.ref_voltage = amp_ctrl[SACFG_VREF_LSB +: 2];
    assign afe.gain_ch1 = first_slot_amp_gain;
    // channels 2-4 switch source on the enable bit
    assign afe.gain_ch2 = first_slot_per_channel_gain_enable ? ch_gain[1:0]
                                                             : first_slot_amp_gain;
    assign afe.gain_ch3 = first_slot_per_channel_gain_enable ? ch_gain[3:2]
                                                             : first_slot_amp_gain;
    assign afe.gain_ch4 = first_slot_per_channel_gain_enable ? ch_gain[5:4]
                                                             : first_slot_amp_gain;
    assign afe.integrator_as_buffer = amp_ctrl[SACFG_AS_BUF_BIT];
    assign afe.per_channel_gain_enable = first_slot_per_channel_gain_enable;
    assign afe.full_analog_chain_mode = path_full;
    // buffer path only counts when software kept its side of the bargain
    wire logic buf_path_armed = path_buf && amp_ctrl[SACFG_AS_BUF_BIT];
    assign afe.amp_to_adc_mode = path_nobuf || buf_path_armed;
    assign afe.path_reserved = !(path_full || path_buf || path_nobuf);
endmodule // sacfg_decode

// ### logic/sacfg_regs.sv
// axi4-lite register bank for the first slot afe configuration
//
// The AXI4-Lite register port was chosen for this implementation.
module sacfg_regs (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output sacfg_pkg::sacfg_afe_s afe_cfg
);
    import sacfg_pkg::*;
    // one write and one read at a time; a second request simply waits on ready

    // stored words, one per mapped index
    logic [15:0] amp_q; // amp control: gain, vref, per-channel enable, buffer bit
    logic [15:0] path_q; // path select code, reserved codes kept as written
    logic [15:0] chg_q; // gains of channels two to four, only bits 5:0 live
    // captured write address and data, held until both have arrived
    logic aw_have_q; // address half taken, waiting for commit
    logic w_have_q; // data half taken, waiting for commit
    logic [7:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q; // write response pending
    logic rvalid_q; // read data pending
    logic [1:0] bresp_q; // code of the pending write response
    logic [1:0] rresp_q; // code of the pending read response
    logic [31:0] rdata_q;

    // ready while the slot is free and no response waits
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    // responses come straight from flip-flops so the bus never sees a glitch
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // a half is taken at the edge where its valid meets its ready
    wire logic aw_hs = s_axi_awvalid && s_axi_awready;
    wire logic w_hs = s_axi_wvalid && s_axi_wready;
    wire logic ar_hs = s_axi_arvalid && s_axi_arready;
    // commit when both halves present
    wire logic do_write = aw_have_q && w_have_q && !bvalid_q;
    // commit waits for the old response, so a pending bresp is never overwritten
    wire logic wr_amp = do_write && (aw_idx_q == SACFG_AMP_CTRL_IDX);
    wire logic wr_path = do_write && (aw_idx_q == SACFG_PATH_SEL_IDX);
    wire logic wr_chg = do_write && (aw_idx_q == SACFG_CH_GAIN_IDX);
    wire logic wr_hit = wr_amp || wr_path || wr_chg;
    // byte merge of the low two lanes; upper lanes land in no storage
    wire logic [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire logic [15:0] amp_d = (amp_q & ~wmask) | (wdata_q[15:0] & wmask);
    wire logic [15:0] path_d = (path_q & ~wmask) | (wdata_q[15:0] & wmask);
    wire logic [15:0] chg_d = (chg_q & ~wmask) | (wdata_q[15:0] & wmask);
    // read decode: index is byte address over four
    wire logic [7:0] ar_idx = s_axi_araddr[9:2];
    wire logic rd_amp = (ar_idx == SACFG_AMP_CTRL_IDX);
    wire logic rd_path = (ar_idx == SACFG_PATH_SEL_IDX);
    wire logic rd_chg = (ar_idx == SACFG_CH_GAIN_IDX);
    // unmapped indices read as zero
    wire logic [15:0] rd_word = rd_amp ? amp_q : rd_path ? path_q : rd_chg ? chg_q : 16'h0000;

    // write channel capture
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            // address half: taken once, then ready drops until the write response is taken
            if (aw_hs) begin
                aw_have_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[9:2];
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            // data half: strobes travel with the data
            if (w_hs) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // storage, reads return what was written, except chg_q, which keeps only bits 5:0
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            amp_q <= SACFG_AMP_CTRL_RST;
            path_q <= SACFG_PATH_SEL_RST;
            chg_q <= SACFG_CH_GAIN_RST;
        end else begin
            // a write to an unmapped index touches nothing, so a stray address is harmless
            if (wr_amp) amp_q <= amp_d;
            if (wr_path) path_q <= path_d;
            if (wr_chg) chg_q <= {10'h000, chg_d[5:0]};
        end
    end

    // write response
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q <= SACFG_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            // an unmapped index still completes, with an error code
            bresp_q <= wr_hit ? SACFG_RESP_OKAY : SACFG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read response, one cycle after address
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rresp_q <= SACFG_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rresp_q <= (rd_amp || rd_path || rd_chg) ? SACFG_RESP_OKAY : SACFG_RESP_SLVERR;
            // address decoded straight off the bus; no capture stage needed
            rdata_q <= {16'h0000, rd_word};
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // analog settings decode
    // pure logic, so settings follow a stored word in the cycle it lands
    sacfg_decode u_decode (
        .amp_ctrl(amp_q),
        .path_sel(path_q),
        .ch_gain(chg_q),
        .afe(afe_cfg)
    );

    // checks
    // reset values, sampled at the first edge after release
    a_vref_reset: assert property (@(posedge core_clk) $rose(rst_b) |->
        amp_q[5:4] == 2'h3)
        else $error("vref field not 3 after reset");
    a_gain_reset: assert property (@(posedge core_clk) $rose(rst_b) |->
        amp_q[1:0] == 2'h0)
        else $error("gain field not 0 after reset");
    a_path_reset: assert property (@(posedge core_clk) $rose(rst_b) |->
        path_q == SACFG_PATH_FULL)
        else $error("path word not full chain after reset");
    // gain routing
    a_ind_gain_src: assert property (@(posedge core_clk) disable iff (!rst_b)
        amp_q[6] |-> afe_cfg.gain_ch4 == chg_q[5:4] && afe_cfg.gain_ch1 == amp_q[1:0])
        else $error("per-channel gain source wrong");
    a_ind_gain_mid: assert property (@(posedge core_clk) disable iff (!rst_b)
        amp_q[6] |-> afe_cfg.gain_ch2 == chg_q[1:0] && afe_cfg.gain_ch3 == chg_q[3:2])
        else $error("per-channel gain of channels two and three wrong");
    a_common_gain: assert property (@(posedge core_clk) disable iff (!rst_b)
        !amp_q[6] |-> afe_cfg.gain_ch2 == amp_q[1:0] && afe_cfg.gain_ch3 == amp_q[1:0])
        else $error("common gain not applied");
    a_buf_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
        afe_cfg.integrator_as_buffer == amp_q[7])
        else $error("buffer bit not passed");
    // path decode
    a_full_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        path_q == SACFG_PATH_FULL |-> afe_cfg.full_analog_chain_mode && !afe_cfg.path_reserved)
        else $error("full chain code not decoded");
    a_buf_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        path_q == SACFG_PATH_BUF && !amp_q[7] |-> !afe_cfg.amp_to_adc_mode)
        else $error("buffer path without buffer bit");
    a_nobuf_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        path_q == SACFG_PATH_NOBUF |-> afe_cfg.amp_to_adc_mode)
        else $error("plain path code not decoded");
    // storage and bus behaviour
    a_write_back: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_path && wstrb_q[1:0] == 2'h3 |=> path_q == $past(wdata_q[15:0]))
        else $error("path word not stored");
    a_read_back: assert property (@(posedge core_clk) disable iff (!rst_b)
        ar_hs && rd_amp && !wr_amp |=> rvalid_q && rdata_q == {16'h0000, amp_q})
        else $error("read data mismatch");
    // stored words change only on a write to their own index
    a_amp_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !wr_amp |=> $stable(amp_q))
        else $error("amp control changed without a write");
    a_path_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !wr_path |=> $stable(path_q))
        else $error("path word changed without a write");
    a_chg_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !wr_chg |=> $stable(chg_q))
        else $error("channel gain word changed without a write");
    // indices above the bank answer with an error and zero data
    a_wr_unmapped: assert property (@(posedge core_clk) disable iff (!rst_b)
        do_write && aw_idx_q > SACFG_CH_GAIN_IDX |=>
        s_axi_bvalid && s_axi_bresp == SACFG_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_rd_unmapped: assert property (@(posedge core_clk) disable iff (!rst_b)
        ar_hs && ar_idx > SACFG_CH_GAIN_IDX |=>
        s_axi_rvalid && s_axi_rresp == SACFG_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");

    c_write_amp: cover property (@(posedge core_clk) wr_amp);
    c_read_path: cover property (@(posedge core_clk) ar_hs && rd_path);
    c_ind_en: cover property (@(posedge core_clk) amp_q[6]);
    c_bad_addr: cover property (@(posedge core_clk) s_axi_bvalid && s_axi_bresp == SACFG_RESP_SLVERR);
    c_buf_path: cover property (@(posedge core_clk) path_q == SACFG_PATH_BUF && amp_q[7]);
endmodule // sacfg_regs

// ### verification/sacfg_host.sv
// host-side axi4-lite master model with register access tasks
module sacfg_host (
    input wire logic core_clk,
    output logic [9:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [9:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus idle from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
    end
    // one write; handshakes judged mid-cycle so the edge itself never races
    task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge core_clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask
    // one read; data sampled mid-cycle, at the falling edge where rvalid meets rready
    task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        v = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v) begin
            @(negedge core_clk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) s_axi_rready <= 1'b0;
        end
    endtask
endmodule // sacfg_host

// ### verification/sacfg_regs_tb.sv
// self-checking bench for the first slot afe configuration registers
module sacfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sacfg_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    sacfg_afe_s afe_cfg;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    sacfg_regs dut (.*);
    sacfg_host host (.*);
    always #25 core_clk = ~core_clk;
    // cut a hang short; the whole run needs about a hundred cycles
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic wr_chk(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, d, s, r);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk(10'h108, 32'h0000_0030, SACFG_RESP_OKAY);
        rd_chk(10'h10C, 32'h0000_ADA5, SACFG_RESP_OKAY);
        chk(32'({afe_cfg.ref_voltage, afe_cfg.full_analog_chain_mode}), 32'h7);
        $display("test reset_values done");
        // upper bits of the channel gain word are not stored
        wr_chk(10'h154, 16'hFFE4, 4'hF, SACFG_RESP_OKAY);
        rd_chk(10'h154, 32'h0000_0024, SACFG_RESP_OKAY);
        // shared gain must ignore the channel word while per-channel mode is off
        for (int i = 0; i < 4; i++) begin
            wr_chk(10'h108, 16'(i * 16'h0011), 4'hF, SACFG_RESP_OKAY);
            rd_chk(10'h108, 32'(i * 16'h0011), SACFG_RESP_OKAY);
            chk(32'(afe_cfg.ref_voltage), 32'(i));
            chk(32'({afe_cfg.gain_ch1, afe_cfg.gain_ch4}), 32'(i * 5));
            chk(32'({afe_cfg.gain_ch2, afe_cfg.gain_ch3}), 32'(i * 5));
        end
        wr_chk(10'h108, 16'h0043, 4'hF, SACFG_RESP_OKAY);
        chk(32'({afe_cfg.gain_ch4, afe_cfg.gain_ch3, afe_cfg.gain_ch2}), 32'h24);
        chk(32'({afe_cfg.per_channel_gain_enable, afe_cfg.gain_ch1}), 32'h7);
        $display("test gains done");
        // buffer bit set before the buffered path code, cleared before the other
        wr_chk(10'h108, 16'h00B0, 4'hF, SACFG_RESP_OKAY);
        wr_chk(10'h10C, SACFG_PATH_BUF, 4'hF, SACFG_RESP_OKAY);
        chk(32'({afe_cfg.integrator_as_buffer, afe_cfg.amp_to_adc_mode}), 32'h3);
        wr_chk(10'h108, 16'h0030, 4'hF, SACFG_RESP_OKAY);
        wr_chk(10'h10C, SACFG_PATH_NOBUF, 4'hF, SACFG_RESP_OKAY);
        chk(32'({afe_cfg.integrator_as_buffer, afe_cfg.amp_to_adc_mode}), 32'h1);
        wr_chk(10'h10C, 16'h1234, 4'hF, SACFG_RESP_OKAY);
        rd_chk(10'h10C, 32'h0000_1234, SACFG_RESP_OKAY);
        chk(32'({afe_cfg.path_reserved, afe_cfg.full_analog_chain_mode}), 32'h2);
        // a strobe on lane one alone changes only the upper byte
        wr_chk(10'h10C, 16'hABCD, 4'h2, SACFG_RESP_OKAY);
        rd_chk(10'h10C, 32'h0000_AB34, SACFG_RESP_OKAY);
        $display("test path_modes done");
        // unmapped place answers with an error and reads zero
        wr_chk(10'h200, 16'h5555, 4'hF, SACFG_RESP_SLVERR);
        rd_chk(10'h200, 32'h0000_0000, SACFG_RESP_SLVERR);
        // a second reset restores every field
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk(10'h10C, 32'h0000_ADA5, SACFG_RESP_OKAY);
        rd_chk(10'h108, 32'h0000_0030, SACFG_RESP_OKAY);
        rd_chk(10'h154, 32'h0000_0000, SACFG_RESP_OKAY);
        $display("test errors_and_reset done");
        summarize();
    end
endmodule // sacfg_regs_tb
